// ===== src/pcmt_pkg.sv
// Package: register map, field positions and modes of the compare timer
package pcmt_pkg;

  // ==========================================================
  // Widths
  localparam int CNT_WIDTH   = 24;       // Up counter and compare width
  localparam int PSC_WIDTH   = 8;        // Prescale field width
  localparam int ADDR_WIDTH  = 8;        // Register port address width
  localparam int DATA_WIDTH  = 32;       // Register port data width
  localparam int IRQ_BITS    = 3;        // Sticky status bits

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL  = 8'h00; // timer_control
  localparam logic [7:0] OFS_COMPARE  = 8'h04; // timer0_compare_value
  localparam logic [7:0] OFS_STATUS   = 8'h08; // Sticky event status, RO
  localparam logic [7:0] OFS_MIRROR   = 8'h0c; // count_mirror, RO
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h40; // Write one to clear, WO
  localparam logic [7:0] OFS_IRQ_EN   = 8'h44; // Interrupt enables, RW
  localparam logic [7:0] OFS_CMP_ALT  = 8'h24; // timer1_compare_value slot

  // ==========================================================
  // Control register fields
  localparam int CTL_PSC_LSB     = 0;    // prescale_divisor [7:0]
  localparam int CTL_MIRROR_EN   = 16;   // mirror_update_enable
  localparam int CTL_CMP_POLICY  = 17;   // compare_write_policy
  localparam int CTL_WAKE_EN     = 23;   // wake_trigger_enable
  localparam int CTL_EXT_CNT_EN  = 24;   // external_event_count_enable
  localparam int CTL_ACTIVE      = 25;   // Counter active, read only
  localparam int CTL_RESET_CNT   = 26;   // Self clearing counter reset
  localparam int CTL_MODE_LSB    = 27;   // operating_mode_select [28:27]
  localparam int CTL_INT_EN      = 29;   // Match interrupt enable
  localparam int CTL_COUNT_EN    = 30;   // counting_enable

  // ==========================================================
  // Status bit positions
  localparam int STS_MATCH   = 0;        // match_flag
  localparam int STS_WAKE    = 1;        // Wake-up flag
  localparam int STS_CAPTURE = 2;        // capture_flag

  // ==========================================================
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000; // All registers

  // Operating modes
  typedef enum logic [1:0] {
    PCMT_ONE_SHOT   = 2'h0,
    PCMT_PERIODIC   = 2'h1,
    PCMT_TOGGLE     = 2'h2,
    PCMT_CONTINUOUS = 2'h3
  } pcmt_mode_t;

endpackage

// ===== src/pcmt_prescaler.sv
// Prescale divider producing one advance pulse every div+1 clocks
`timescale 1ns/1ps

module pcmt_prescaler
  import pcmt_pkg::*;
#(
  parameter int PSC_W = PSC_WIDTH         // Divider field width
) (
  input  wire logic             mclk,     // Timer clock
  input  wire logic             reset,    // Synchronous, active high
  input  wire logic             run,      // Counting enabled
  input  wire logic             clear,    // Restart division
  input  wire logic [PSC_W-1:0] div,      // Divide by div+1
  output logic                  tick      // Advance the up counter
);

  // ==========================================================
  // Elaboration check; a zero-width divider has no period
  if (PSC_W < 1) begin : g_bad_w
    $error("pcmt_prescaler: PSC_W must be at least 1");
  end

  // ==========================================================
  // Divider state
  logic [PSC_W-1:0] pcnt_ff;              // Clocks seen in this period
  logic [PSC_W-1:0] nxt_pcnt;             // Next divider value
  wire  logic       at_end;               // Period complete

  assign at_end = (pcnt_ff >= div);       // >= so a lowered div never hangs
  assign tick   = run & at_end & ~clear;

  // Zero on clear, wrap at period end, hold while stopped
  assign nxt_pcnt = clear ? '0 :
                    ~run  ? pcnt_ff :
                    at_end ? '0 : pcnt_ff + PSC_W'(1);

  // ==========================================================
  // Divider register
  always_ff @(posedge mclk) begin
    if (reset) begin
      pcnt_ff <= '0;
    end else begin
      pcnt_ff <= nxt_pcnt;
    end
  end

endmodule // pcmt_prescaler

// ===== src/pcmt_irq.sv
// Sticky event status, write-one clear, enables and the interrupt line
`timescale 1ns/1ps

module pcmt_irq
  import pcmt_pkg::*;
#(
  parameter int N = IRQ_BITS              // Number of event bits
) (
  input  wire logic         mclk,         // Timer clock
  input  wire logic         reset,        // Synchronous, active high
  input  wire logic [N-1:0] set_vec,      // Event pulses
  input  wire logic         clr_wr,       // Clear register written
  input  wire logic [N-1:0] clr_data,     // Ones clear status bits
  input  wire logic         en_wr,        // Enable register written
  input  wire logic [N-1:0] en_data,      // New enables
  input  wire logic [N-1:0] gate,         // Extra per-bit gating
  output logic      [N-1:0] status,       // Sticky status
  output logic      [N-1:0] enable,       // Enable register
  output logic              irq           // Level interrupt
);

  // ==========================================================
  // Elaboration check; at least one event bit is needed
  if (N < 1) begin : g_bad_n
    $error("pcmt_irq: N must be at least 1");
  end

  // ==========================================================
  // Per-bit sticky flags; a set in the clear cycle wins
  logic [N-1:0] sts_ff;                   // Sticky flags
  logic [N-1:0] en_ff;                    // Enable bits

  for (genvar i = 0; i < N; i++) begin : g_bit
    wire logic nxt_sts;                   // Next flag value
    assign nxt_sts = set_vec[i] | (sts_ff[i] & ~(clr_wr & clr_data[i]));
    always_ff @(posedge mclk) begin
      if (reset) begin
        sts_ff[i] <= 1'b0;
      end else begin
        sts_ff[i] <= nxt_sts;
      end
    end
  end

  // ==========================================================
  // Enable register
  always_ff @(posedge mclk) begin
    if (reset) begin
      en_ff <= '0;
    end else if (en_wr) begin
      en_ff <= en_data;
    end
  end

  assign status = sts_ff;
  assign enable = en_ff;
  assign irq    = |(sts_ff & en_ff & gate);

endmodule // pcmt_irq

// ===== src/pcmt_timer.sv
// Prescaled 24-bit compare timer with register port and wake trigger
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps

module pcmt_timer
  import pcmt_pkg::*;
#(
  parameter int CNT_W = CNT_WIDTH,        // Counter and compare width
  parameter int PSC_W = PSC_WIDTH         // Prescale field width
) (
  input  wire logic                  mclk,          // 250 MHz clock
  input  wire logic                  reset,         // Sync, active high
  input  wire logic [ADDR_WIDTH-1:0] addr,          // Register byte addr
  input  wire logic [DATA_WIDTH-1:0] wdata,         // Write data
  input  wire logic                  wr,            // Write strobe
  input  wire logic                  rd,            // Read strobe
  output logic      [DATA_WIDTH-1:0] rdata,         // Read data, next cycle
  input  wire logic                  capture_event, // Capture pulse, mclk
  output logic                       wake_trigger,  // Wake-up pulse
  output logic                       toggle_out,    // Toggle mode output
  output logic                       irq            // Level interrupt
);

  // ==========================================================
  // Elaboration checks
  if (CNT_W < 2 || CNT_W > CNT_WIDTH) begin : g_bad_cnt
    $error("pcmt_timer: CNT_W out of range");
  end
  if (PSC_W < 1 || PSC_W > PSC_WIDTH) begin : g_bad_psc
    $error("pcmt_timer: PSC_W out of range");
  end

  // ==========================================================
  // Control and data registers
  logic [PSC_W-1:0] psc_ff;               // prescale_divisor
  logic             mirror_en_ff;         // mirror_update_enable
  logic             policy_ff;            // compare_write_policy
  logic             wake_en_ff;           // wake_trigger_enable
  logic             ext_cnt_en_ff;        // Stored only, no event input
  pcmt_mode_t       mode_ff;              // operating_mode_select
  logic             int_en_ff;            // Match interrupt enable
  logic             counting_enable_ff;             // counting_enable
  logic [CNT_W-1:0] cmp_ff;               // compare_value
  logic [CNT_W-1:0] cnt_ff;               // Internal up counter
  logic [CNT_W-1:0] mirror_ff;            // count_mirror
  logic [DATA_WIDTH-1:0] rdata_ff;        // Registered read data
  logic             wake_ff;              // Wake pulse register
  logic             toggle_ff;            // Toggle output register

  // ==========================================================
  // Address decode
  wire logic sel_ctl;                     // Control register hit
  wire logic sel_cmp;                     // Compare register hit
  wire logic sel_sts;                     // Status register hit
  wire logic sel_mir;                     // Mirror register hit
  wire logic sel_clr;                     // Clear register hit
  wire logic sel_ien;                     // Enable register hit

  assign sel_ctl = (addr == OFS_CONTROL);
  assign sel_cmp = (addr == OFS_COMPARE);
  assign sel_sts = (addr == OFS_STATUS);
  assign sel_mir = (addr == OFS_MIRROR);
  assign sel_clr = (addr == OFS_IRQ_CLR);
  assign sel_ien = (addr == OFS_IRQ_EN);

  wire logic wr_ctl;                      // Control write this cycle
  wire logic wr_cmp;                      // Compare write this cycle

  assign wr_ctl = wr & sel_ctl;
  assign wr_cmp = wr & sel_cmp;

  // ==========================================================
  // Write data fields
  wire logic [CNT_W-1:0] new_cmp;         // Incoming compare value
  wire logic             w_counting_enable;         // Incoming counting enable
  wire logic             w_rstcnt;        // Incoming counter reset
  wire pcmt_mode_t       w_mode;          // Incoming mode

  assign new_cmp  = wdata[CNT_W-1:0];
  assign w_counting_enable  = wdata[CTL_COUNT_EN];
  assign w_rstcnt = wdata[CTL_RESET_CNT];
  assign w_mode   = pcmt_mode_t'(wdata[CTL_MODE_LSB +: 2]);

  // ==========================================================
  // Compare-write restart decision
  // Continuous mode never restarts; the other modes restart unless
  // the policy bit is set and the new value is still ahead.
  wire logic mode_cont;                   // Continuous counting mode
  wire logic cmp_ahead;                   // New compare beyond count
  wire logic cmp_restart;                 // Compare write restarts

  assign mode_cont   = (mode_ff == PCMT_CONTINUOUS);
  assign cmp_ahead   = (new_cmp > cnt_ff);
  assign cmp_restart = wr_cmp & ~mode_cont &
                       (~policy_ff | ~cmp_ahead);

  // Software counter reset only acts while the counter is active
  wire logic sw_reset;                    // Control reset request
  assign sw_reset = wr_ctl & w_rstcnt & counting_enable_ff;

  wire logic cnt_clear;                   // Any counter restart
  assign cnt_clear = cmp_restart | sw_reset;

  // ==========================================================
  // Prescaler
  wire logic tick;                        // Counter advance pulse

  pcmt_prescaler #(
    .PSC_W (PSC_W)
  ) u_psc (
    .mclk  (mclk),
    .reset (reset),
    .run   (counting_enable_ff),
    .clear (cnt_clear),
    .div   (psc_ff),
    .tick  (tick)
  );

  // ==========================================================
  // Match detection
  // Compare is against the value the counter is about to take, so
  // the flag rises after exactly cmp ticks: (psc+1)*cmp clocks.
  // A compare of zero is left unsupported, as software avoids it.
  wire logic [CNT_W-1:0] cnt_inc;         // Counter plus one
  wire logic             hit;             // Counter reaches compare

  assign cnt_inc = cnt_ff + CNT_W'(1);
  assign hit     = tick & (cnt_inc == cmp_ff);

  // ==========================================================
  // Next counter value
  wire logic [CNT_W-1:0] nxt_cnt;         // Next up counter

  assign nxt_cnt = cnt_clear        ? '0 :
                   (hit & ~mode_cont) ? '0 :
                   tick             ? cnt_inc :
                   cnt_ff;

  // ==========================================================
  // Next counting enable
  // One-shot drops the enable at match; a software reset also stops.
  wire logic nxt_counting_enable;                   // Next counting enable

  assign nxt_counting_enable = wr_ctl ? (w_counting_enable & ~sw_reset) :
                     (hit & (mode_ff == PCMT_ONE_SHOT)) ? 1'b0 :
                     counting_enable_ff;

  // ==========================================================
  // Control register
  always_ff @(posedge mclk) begin
    if (reset) begin
      psc_ff        <= '0;
      mirror_en_ff  <= 1'b0;
      policy_ff     <= 1'b0;
      wake_en_ff    <= 1'b0;
      ext_cnt_en_ff <= 1'b0;
      mode_ff       <= PCMT_ONE_SHOT;
      int_en_ff     <= 1'b0;
    end else if (wr_ctl) begin
      // Only defined fields are stored; reserved bits drop
      psc_ff        <= wdata[CTL_PSC_LSB +: PSC_W];
      mirror_en_ff  <= wdata[CTL_MIRROR_EN];
      policy_ff     <= wdata[CTL_CMP_POLICY];
      wake_en_ff    <= wdata[CTL_WAKE_EN];
      ext_cnt_en_ff <= wdata[CTL_EXT_CNT_EN];
      mode_ff       <= w_mode;
      int_en_ff     <= wdata[CTL_INT_EN];
    end
  end

  // ==========================================================
  // Counter and enable
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_ff   <= '0;
      counting_enable_ff <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      counting_enable_ff <= nxt_counting_enable;
    end
  end

  // ==========================================================
  // Compare register
  always_ff @(posedge mclk) begin
    if (reset) begin
      cmp_ff <= '0;
    end else if (wr_cmp) begin
      cmp_ff <= new_cmp;                  // Newest value used at once
    end
  end

  // ==========================================================
  // Count mirror; frozen when disabled or stopped
  always_ff @(posedge mclk) begin
    if (reset) begin
      mirror_ff <= '0;
    end else if (mirror_en_ff & counting_enable_ff) begin
      mirror_ff <= cnt_ff;
    end
  end

  // ==========================================================
  // Toggle output flips on every match in toggle mode
  always_ff @(posedge mclk) begin
    if (reset) begin
      toggle_ff <= 1'b0;
    end else if (hit & (mode_ff == PCMT_TOGGLE)) begin
      toggle_ff <= ~toggle_ff;
    end
  end

  // ==========================================================
  // Wake trigger
  // Pulses on the event that sets a flag, not on the flag level,
  // so a stale flag does not retrigger the processor forever.
  wire logic wake_evt;                    // Wake condition this cycle
  assign wake_evt = wake_en_ff & (hit | capture_event);

  always_ff @(posedge mclk) begin
    if (reset) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= wake_evt;
    end
  end

  // ==========================================================
  // Sticky status and interrupt
  wire logic [IRQ_BITS-1:0] set_vec;      // Event pulses
  wire logic [IRQ_BITS-1:0] gate_vec;     // Per-bit gating
  wire logic [IRQ_BITS-1:0] sts_vec;      // Status bits
  wire logic [IRQ_BITS-1:0] ien_vec;      // Enable bits

  assign set_vec[STS_MATCH]   = hit;
  assign set_vec[STS_WAKE]    = wake_evt;
  assign set_vec[STS_CAPTURE] = capture_event;
  assign gate_vec[STS_MATCH]   = int_en_ff;
  assign gate_vec[STS_WAKE]    = 1'b1;
  assign gate_vec[STS_CAPTURE] = 1'b1;

  pcmt_irq #(
    .N (IRQ_BITS)
  ) u_irq (
    .mclk     (mclk),
    .reset    (reset),
    .set_vec  (set_vec),
    .clr_wr   (wr & sel_clr),
    .clr_data (wdata[IRQ_BITS-1:0]),
    .en_wr    (wr & sel_ien),
    .en_data  (wdata[IRQ_BITS-1:0]),
    .gate     (gate_vec),
    .status   (sts_vec),
    .enable   (ien_vec),
    .irq      (irq)
  );

  // ==========================================================
  // Read word assembly; unlisted bits stay zero
  logic [DATA_WIDTH-1:0] ctl_word;        // Control readback
  logic [DATA_WIDTH-1:0] rd_word;         // Selected read word

  always_comb begin
    ctl_word = RST_WORD;
    ctl_word[CTL_PSC_LSB +: PSC_W] = psc_ff;
    ctl_word[CTL_MIRROR_EN]        = mirror_en_ff;
    ctl_word[CTL_CMP_POLICY]       = policy_ff;
    ctl_word[CTL_WAKE_EN]          = wake_en_ff;
    ctl_word[CTL_EXT_CNT_EN]       = ext_cnt_en_ff;
    ctl_word[CTL_ACTIVE]           = counting_enable_ff;
    ctl_word[CTL_MODE_LSB +: 2]    = mode_ff;
    ctl_word[CTL_INT_EN]           = int_en_ff;
    ctl_word[CTL_COUNT_EN]         = counting_enable_ff;
  end

  // Write-only clear register and unmapped addresses read zero
  always_comb begin
    rd_word = RST_WORD;
    if (sel_ctl) begin
      rd_word = ctl_word;
    end else if (sel_cmp) begin
      rd_word[CNT_W-1:0] = cmp_ff;
    end else if (sel_sts) begin
      rd_word[IRQ_BITS-1:0] = sts_vec;
    end else if (sel_mir) begin
      rd_word[CNT_W-1:0] = mirror_ff;
    end else if (sel_ien) begin
      rd_word[IRQ_BITS-1:0] = ien_vec;
    end
  end

  // ==========================================================
  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_ff <= RST_WORD;
    end else begin
      rdata_ff <= rd ? rd_word : RST_WORD;
    end
  end

  assign rdata        = rdata_ff;
  assign wake_trigger = wake_ff;
  assign toggle_out   = toggle_ff;

endmodule // pcmt_timer

// ===== verification/pcmt_timer_sva.sv
// Checker: register port and event relations of the compare timer
`timescale 1ns/1ps

module pcmt_timer_chk
  import pcmt_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  reset,
  input wire logic [ADDR_WIDTH-1:0] addr,
  input wire logic [DATA_WIDTH-1:0] wdata,
  input wire logic                  wr,
  input wire logic                  rd,
  input wire logic [DATA_WIDTH-1:0] rdata,
  input wire logic                  capture_event,
  input wire logic                  wake_trigger,
  input wire logic                  toggle_out,
  input wire logic                  irq
);
  // ==========================================================
  // Shadows of the software-held bits
  logic [31:0] ctl_ff; // Stored control bits, hardware bits masked
  logic [2:0]  en_ff;  // Interrupt enables

  default clocking dc @(posedge mclk); endclocking
  default disable iff (reset);

  // Track writes; enable and active bits left out, hardware moves them
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctl_ff <= 32'h0;
      en_ff  <= 3'h0;
    end else if (wr && addr == OFS_CONTROL) begin
      ctl_ff <= wdata & 32'h398300ff;
    end else if (wr && addr == OFS_IRQ_EN) begin
      en_ff <= wdata[2:0];
    end
  end

  // ==========================================================
  // Read port
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_ctl_read_back: assert property ($past(rd) &&
    $past(addr) == OFS_CONTROL |-> (rdata & 32'hbdffffff) == $past(ctl_ff))
    else $error("control read back differs from what was written");
  a_active_follows_en: assert property ($past(rd) &&
    $past(addr) == OFS_CONTROL |-> rdata[25] == rdata[30])
    else $error("active bit differs from counting enable");
  a_cmp_upper_zero: assert property ($past(rd) &&
    $past(addr) == OFS_COMPARE |-> rdata[31:24] == 8'h0)
    else $error("compare reserved bits not zero");
  a_mirror_upper_zero: assert property ($past(rd) &&
    $past(addr) == OFS_MIRROR |-> rdata[31:24] == 8'h0)
    else $error("mirror reserved bits not zero");
  a_status_upper_zero: assert property ($past(rd) &&
    $past(addr) == OFS_STATUS |-> rdata[31:3] == 29'h0)
    else $error("status reserved bits not zero");
  a_unmapped_zero: assert property ($past(rd) &&
    ($past(addr) == OFS_CMP_ALT || $past(addr) == OFS_IRQ_CLR) |->
    rdata == 32'h0)
    else $error("unmapped or write-only place read non-zero");

  // ==========================================================
  // Events and interrupt
  a_wake_on_capture: assert property (capture_event &&
    ctl_ff[23] |=> wake_trigger)
    else $error("capture with wake enabled gave no wake pulse");
  a_wake_needs_en: assert property (wake_trigger |-> $past(ctl_ff[23]))
    else $error("wake pulse while wake disabled");
  a_irq_sticky: assert property (irq && !wr |=> irq)
    else $error("interrupt fell without a register write");
  a_irq_masked: assert property (en_ff == 3'h0 |-> !irq)
    else $error("interrupt high with all enables clear");

endmodule // pcmt_timer_chk

// ===== verification/pcmt_timer_test.sv
// Testbench: register-level regression of the compare timer
`timescale 1ns/1ps

module pcmt_timer_test
  import pcmt_pkg::*;
;
  // ==========================================================
  // Design ports and bench state
  logic                  mclk;
  logic                  reset;
  logic [ADDR_WIDTH-1:0] addr;
  logic [DATA_WIDTH-1:0] wdata;
  logic                  wr;
  logic                  rd;
  logic [DATA_WIDTH-1:0] rdata;
  logic                  capture_event;
  logic                  wake_trigger;
  logic                  toggle_out;
  logic                  irq;
  int                    n_mismatch;  // Failed compares
  int                    checks_done; // All compares
  int                    n;           // Edges waited for irq
  logic [31:0]           v1;          // Sample pair
  logic [31:0]           v2;
  // Prescale and compare pairs for the time-out loop
  int psc_tab [4] = '{0, 1, 3, 255};
  int cmp_tab [4] = '{4, 5, 3, 2};
  // Mode/policy word, new compare, edges to match after the rewrite
  logic [31:0] md_tab [6] = '{32'h08000000, 32'h08020000, 32'h08020000,
                              32'h18000000, 32'h00000000, 32'h10000000};
  int nc_tab [6] = '{30, 30, 6, 30, 30, 30};
  int ex_tab [6] = '{30, 23, 6, 23, 30, 30};
  logic [7:0] rst_tab [5] = '{OFS_CONTROL, OFS_COMPARE, OFS_STATUS,
                              OFS_MIRROR, OFS_IRQ_EN};

  pcmt_timer pcmt_timer_i (
    .mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .capture_event(capture_event),
    .wake_trigger(wake_trigger), .toggle_out(toggle_out), .irq(irq));

  // ==========================================================
  // Clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ==========================================================
  // Access tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write; takes effect at the second edge
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  // One-cycle read; data stands only in the following cycle
  task automatic rget(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rget(a, v);
    check(v, exp);
  endtask

  // Count edges until irq; bounded so a dead timer cannot hang
  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 600) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask

  // Capture pulse, then look at the wake pulse one cycle later
  task automatic cap(input logic exp);
    @(posedge mclk);
    capture_event <= 1'b1;
    @(posedge mclk);
    capture_event <= 1'b0;
    #1 check(wake_trigger, exp);
  endtask

  // Stop and zero the counter, drop all status
  task automatic clean();
    wreg(OFS_CONTROL, 32'h04000000);
    wreg(OFS_IRQ_CLR, 32'h7);
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog, well beyond the expected run
  initial begin
    #80000;
    n_mismatch++;
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    addr = 8'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    capture_event = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    // Reset values, reserved bits, unmapped slots
    foreach (rst_tab[i]) rreg(rst_tab[i], 32'h0);
    wreg(OFS_CONTROL, 32'h81ffff00);
    rreg(OFS_CONTROL, 32'h01830000);
    wreg(OFS_COMPARE, 32'hffffffff);
    rreg(OFS_COMPARE, 32'h00ffffff);
    wreg(OFS_CMP_ALT, 32'h12345678);
    rreg(OFS_CMP_ALT, 32'h0);
    rreg(OFS_IRQ_CLR, 32'h0);
    wreg(OFS_CONTROL, 32'h0);
    wreg(OFS_IRQ_EN, 32'h7);
    // One-shot time-out over prescale values, wake on match enabled
    foreach (psc_tab[i]) begin
      wreg(OFS_COMPARE, cmp_tab[i]);
      wreg(OFS_CONTROL, 32'h60800000 | psc_tab[i]);
      wait_irq();
      check(n, (psc_tab[i] + 1) * cmp_tab[i]);
      check(wake_trigger, 1'b1);
      rreg(OFS_CONTROL, 32'h20800000 | psc_tab[i]);
      rreg(OFS_STATUS, 32'h3);
      wreg(OFS_IRQ_CLR, 32'h3);
    end
    // Compare rewrite seven edges after enabling, per mode and policy
    foreach (md_tab[i]) begin
      wreg(OFS_COMPARE, 32'h14);
      wreg(OFS_CONTROL, 32'h60000000 | md_tab[i]);
      repeat (5) @(posedge mclk);
      wreg(OFS_COMPARE, nc_tab[i]);
      wait_irq();
      check(n, ex_tab[i]);
      clean();
    end
    check(toggle_out, 1'b1);
    // Mirror: back-to-back reads step by one, frozen when disabled
    wreg(OFS_COMPARE, 32'hc8);
    wreg(OFS_CONTROL, 32'h48010000);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= OFS_MIRROR;
    @(posedge mclk);
    #1 v1 = rdata;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v2 = rdata;
    check(v2 - v1, 32'h1);
    wreg(OFS_CONTROL, 32'h48000000);
    rget(OFS_MIRROR, v1);
    rget(OFS_MIRROR, v2);
    check(v2, v1);
    clean();
    // Capture with wake off, then on; sticky status and masking
    cap(1'b0);
    wreg(OFS_CONTROL, 32'h00800000);
    cap(1'b1);
    @(posedge mclk);
    #1 check(wake_trigger, 1'b0);
    rreg(OFS_STATUS, 32'h6);
    repeat (20) @(posedge mclk);
    #1 check(irq, 1'b1);
    wreg(OFS_IRQ_CLR, 32'h0);
    rreg(OFS_STATUS, 32'h6);
    wreg(OFS_IRQ_EN, 32'h1);
    #1 check(irq, 1'b0);
    wreg(OFS_IRQ_CLR, 32'h6);
    rreg(OFS_STATUS, 32'h0);
    conclude();
  end

endmodule // pcmt_timer_test

// Checker attached to every instance of the timer
bind pcmt_timer pcmt_timer_chk pcmt_timer_chk_i (
  .mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .capture_event(capture_event),
  .wake_trigger(wake_trigger), .toggle_out(toggle_out), .irq(irq));
